// >>> core/t8cc_map.svh
`ifndef T8CC_MAP_SVH
`define T8CC_MAP_SVH

`define T8CC_OFF_CTRL 8'h00
`define T8CC_OFF_COUNT 8'h04
`define T8CC_OFF_CMPA 8'h08
`define T8CC_OFF_CMPB 8'h0c
`define T8CC_OFF_FLAGS 8'h10
`define T8CC_OFF_FORCE 8'h14
`define T8CC_OFF_IEN 8'h18

`define T8CC_CTRL_MODE_LSB 0
`define T8CC_CTRL_ACTA_LSB 4
`define T8CC_CTRL_ACTB_LSB 6
`define T8CC_CTRL_CS_LSB 8

`define T8CC_FLAG_A 0
`define T8CC_FLAG_B 1
`define T8CC_FLAG_OVF 2

`define T8CC_MODE_NORMAL 3'h0
`define T8CC_MODE_CTC 3'h2
`define T8CC_CNT_MAX 8'hff
`define T8CC_CNT_BOTTOM 8'h00

`define T8CC_ACT_NONE 2'h0
`define T8CC_ACT_TOGGLE 2'h1
`define T8CC_ACT_CLEAR 2'h2
`define T8CC_ACT_SET 2'h3

`define T8CC_DIV1_MASK 10'h000
`define T8CC_DIV8_MASK 10'h007
`define T8CC_DIV32_MASK 10'h01f
`define T8CC_DIV64_MASK 10'h03f
`define T8CC_DIV128_MASK 10'h07f
`define T8CC_DIV256_MASK 10'h0ff
`define T8CC_DIV1024_MASK 10'h3ff

`define T8CC_RESP_OKAY 2'h0
`define T8CC_RESP_SLVERR 2'h2

`endif

// >>> core/t8cc_pkg.sv
package t8cc_pkg;
	typedef logic [7:0] t8cc_addr_t;
	typedef logic [1:0] t8cc_act_t;

	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic aw_held;
		logic w_held;
		t8cc_addr_t awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [2:0] mode;
		logic [2:0] cs;
		t8cc_act_t act_a;
		t8cc_act_t act_b;
		logic [2:0] ien;
		logic [2:0] flags;
		logic [7:0] cnt;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic [1:0] oc;
		logic block;
		logic [9:0] pre;
		logic [2:0] irq;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
	} t8cc_state_t;
endpackage

// >>> core/t8cc_top.sv
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`include "t8cc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module t8cc_top (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire t8cc_pkg::t8cc_addr_t S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire t8cc_pkg::t8cc_addr_t S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	input wire logic [2:0] IRQ_ACK,
	output logic [2:0] IRQ_REQ,
	input wire logic [1:0] PORT_DATA,
	input wire logic [1:0] PORT_DIR,
	output logic [1:0] PIN_OUT,
	output logic [1:0] PIN_OE
);
	import t8cc_pkg::*;

	t8cc_state_t st;
	t8cc_state_t nx;
	logic [9:0] mask;
	logic tick;
	logic pwm;
	logic eq_a;
	logic eq_b;
	logic hit_a;
	logic hit_b;
	logic bottom;
	logic do_wr;
	logic force_a;
	logic force_b;
	logic [2:0] set_f;
	logic [2:0] clr_f;
	logic [7:0] cnt_step;
	t8cc_addr_t wa;
	t8cc_addr_t ra;

	// next output bit for one channel
	function automatic logic next_oc(input t8cc_act_t act, input logic is_pwm,
			input logic oc, input logic hit, input logic bot);
		logic r;
		r = oc;
		if (act == `T8CC_ACT_NONE) begin
			r = oc;
		end else if (!is_pwm || act == `T8CC_ACT_TOGGLE) begin
			if (hit) begin
				case (act)
					`T8CC_ACT_TOGGLE: r = ~oc;
					`T8CC_ACT_CLEAR: r = 1'b0;
					`T8CC_ACT_SET: r = 1'b1;
					default: r = oc;
				endcase
			end
		end else begin
			// pwm: match sets/clears, bottom restores
			if (hit) begin
				r = (act == `T8CC_ACT_SET);
			end else if (bot) begin
				r = (act == `T8CC_ACT_CLEAR);
			end
		end
		return r;
	endfunction

	always_comb begin
		nx = st;
		case (st.cs)
			3'h1: mask = `T8CC_DIV1_MASK;
			3'h2: mask = `T8CC_DIV8_MASK;
			3'h3: mask = `T8CC_DIV32_MASK;
			3'h4: mask = `T8CC_DIV64_MASK;
			3'h5: mask = `T8CC_DIV128_MASK;
			3'h6: mask = `T8CC_DIV256_MASK;
			3'h7: mask = `T8CC_DIV1024_MASK;
			default: mask = `T8CC_DIV1_MASK;
		endcase
		// source zero halts the divider and the timer
		tick = (st.cs != 3'h0) && ((st.pre & mask) == mask);
		nx.pre = (st.cs == 3'h0) ? 10'h000 : st.pre + 10'h001;
		pwm = st.mode[0];

		eq_a = (st.cnt == st.cmp_a);
		eq_b = (st.cnt == st.cmp_b);
		hit_a = tick && eq_a && !st.block;
		hit_b = tick && eq_b && !st.block;

		// counting; output action never enters here
		cnt_step = st.cnt;
		set_f = 3'h0;
		if (tick) begin
			if (st.mode == `T8CC_MODE_CTC && eq_a) begin
				cnt_step = `T8CC_CNT_BOTTOM;
			end else begin
				cnt_step = st.cnt + 8'h01;
			end
			if (st.cnt == `T8CC_CNT_MAX) begin
				set_f[`T8CC_FLAG_OVF] = 1'b1;
			end
			nx.block = 1'b0;
		end
		nx.cnt = cnt_step;
		bottom = tick && (cnt_step == `T8CC_CNT_BOTTOM);
		set_f[`T8CC_FLAG_A] = hit_a;
		set_f[`T8CC_FLAG_B] = hit_b;

		// pwm buffer load at bottom
		if (pwm && bottom) begin
			nx.cmp_a = st.buf_a;
			nx.cmp_b = st.buf_b;
		end

		// axi write channels, either order
		if (S_AXI_AWVALID && st.aw_rdy) begin
			nx.aw_held = 1'b1;
			nx.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && st.w_rdy) begin
			nx.w_held = 1'b1;
			nx.wdata = S_AXI_WDATA;
			nx.wstrb = S_AXI_WSTRB;
		end
		if (st.bvalid && S_AXI_BREADY) begin
			nx.bvalid = 1'b0;
		end
		do_wr = st.aw_held && st.w_held && !st.bvalid;
		wa = {st.awaddr[7:2], 2'b00};
		force_a = 1'b0;
		force_b = 1'b0;
		clr_f = IRQ_ACK;
		if (do_wr) begin
			nx.aw_held = 1'b0;
			nx.w_held = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = `T8CC_RESP_OKAY;
			case (wa)
				`T8CC_OFF_CTRL: begin
					if (st.wstrb[0]) begin
						nx.mode = st.wdata[`T8CC_CTRL_MODE_LSB +: 3];
						nx.act_a = st.wdata[`T8CC_CTRL_ACTA_LSB +: 2];
						nx.act_b = st.wdata[`T8CC_CTRL_ACTB_LSB +: 2];
					end
					if (st.wstrb[1]) begin
						nx.cs = st.wdata[`T8CC_CTRL_CS_LSB +: 3];
					end
				end
				`T8CC_OFF_COUNT: begin
					if (st.wstrb[0]) begin
						nx.cnt = st.wdata[7:0];
						nx.block = 1'b1;
					end
				end
				`T8CC_OFF_CMPA: begin
					if (st.wstrb[0]) begin
						nx.buf_a = st.wdata[7:0];
						if (!pwm) begin
							nx.cmp_a = st.wdata[7:0];
						end
					end
				end
				`T8CC_OFF_CMPB: begin
					if (st.wstrb[0]) begin
						nx.buf_b = st.wdata[7:0];
						if (!pwm) begin
							nx.cmp_b = st.wdata[7:0];
						end
					end
				end
				`T8CC_OFF_FLAGS: begin
					if (st.wstrb[0]) begin
						clr_f = clr_f | st.wdata[2:0];
					end
				end
				`T8CC_OFF_FORCE: begin
					// strobe only; nothing is stored
					if (st.wstrb[0] && !pwm) begin
						force_a = st.wdata[0];
						force_b = st.wdata[1];
					end
				end
				`T8CC_OFF_IEN: begin
					if (st.wstrb[0]) begin
						nx.ien = st.wdata[2:0];
					end
				end
				default: nx.bresp = `T8CC_RESP_SLVERR;
			endcase
		end
		// a set in the same cycle as a clear wins
		nx.flags = (st.flags & ~clr_f) | set_f;

		nx.oc[0] = next_oc(st.act_a, pwm, st.oc[0], hit_a || force_a, bottom);
		nx.oc[1] = next_oc(st.act_b, pwm, st.oc[1], hit_b || force_b, bottom);

		// axi read
		ra = {S_AXI_ARADDR[7:2], 2'b00};
		if (st.rvalid && S_AXI_RREADY) begin
			nx.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && st.ar_rdy) begin
			nx.rvalid = 1'b1;
			nx.rresp = `T8CC_RESP_OKAY;
			nx.rdata = 32'h0000_0000;
			case (ra)
				`T8CC_OFF_CTRL: begin
					nx.rdata[`T8CC_CTRL_MODE_LSB +: 3] = st.mode;
					nx.rdata[`T8CC_CTRL_ACTA_LSB +: 2] = st.act_a;
					nx.rdata[`T8CC_CTRL_ACTB_LSB +: 2] = st.act_b;
					nx.rdata[`T8CC_CTRL_CS_LSB +: 3] = st.cs;
				end
				`T8CC_OFF_COUNT: nx.rdata[7:0] = st.cnt;
				`T8CC_OFF_CMPA: nx.rdata[7:0] = pwm ? st.buf_a : st.cmp_a;
				`T8CC_OFF_CMPB: nx.rdata[7:0] = pwm ? st.buf_b : st.cmp_b;
				`T8CC_OFF_FLAGS: nx.rdata[2:0] = st.flags;
				`T8CC_OFF_FORCE: nx.rdata = 32'h0000_0000;
				`T8CC_OFF_IEN: nx.rdata[2:0] = st.ien;
				default: nx.rresp = `T8CC_RESP_SLVERR;
			endcase
		end
		nx.aw_rdy = !nx.aw_held && !nx.bvalid;
		nx.w_rdy = !nx.w_held && !nx.bvalid;
		nx.ar_rdy = !nx.rvalid;

		nx.irq = nx.flags & nx.ien;
		// port override, independent of waveform mode
		nx.pin_out[0] = (nx.act_a != `T8CC_ACT_NONE) ? nx.oc[0] : PORT_DATA[0];
		nx.pin_out[1] = (nx.act_b != `T8CC_ACT_NONE) ? nx.oc[1] : PORT_DATA[1];
		nx.pin_oe = PORT_DIR;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign S_AXI_AWREADY = st.aw_rdy;
	assign S_AXI_WREADY = st.w_rdy;
	assign S_AXI_BVALID = st.bvalid;
	assign S_AXI_BRESP = st.bresp;
	assign S_AXI_ARREADY = st.ar_rdy;
	assign S_AXI_RVALID = st.rvalid;
	assign S_AXI_RDATA = st.rdata;
	assign S_AXI_RRESP = st.rresp;
	assign IRQ_REQ = st.irq;
	assign PIN_OUT = st.pin_out;
	assign PIN_OE = st.pin_oe;
endmodule
`default_nettype wire

// >>> tb/t8cc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module t8cc_chk (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] PORT_DIR,
	input wire logic [1:0] PIN_OE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	chk_oe_dir: assert property (!$past(SRST) |-> PIN_OE == $past(PORT_DIR))
		else $error("pin enable lost direction");
	chk_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
	chk_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
	chk_b_timing: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
		S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer late");
	chk_r_timing: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
		S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer late");
	chk_w_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken during response");
	chk_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("response not released");
	chk_resp_code: assert property (S_AXI_BVALID |-> S_AXI_BRESP inside {2'h0, 2'h2})
		else $error("bad write response");
	cover property (S_AXI_BVALID && S_AXI_BREADY);
	cover property (S_AXI_RVALID && S_AXI_RREADY);
	cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule
bind t8cc_top t8cc_chk u_chk (.SYS_CLK, .SRST, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
	.PORT_DIR, .PIN_OE);
`default_nettype wire

// >>> tb/t8cc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module t8cc_top_test;
	logic clk, srst, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [2:0] ack, irq;
	logic [1:0] pdat, pdir, pin, oe, br, rr;
	logic [33:0] bq[$], rq[$];
	logic [4:0] hs;
	assign hs = {rv, arr, bv, wr_r, awr};
	int num_errors = 0, compares = 0, seed = 90843;
	t8cc_top dut (.SYS_CLK(clk), .SRST(srst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
		.S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rr), .IRQ_ACK(ack), .IRQ_REQ(irq), .PORT_DATA(pdat),
		.PORT_DIR(pdir), .PIN_OUT(pin), .PIN_OE(oe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic report_and_stop;
		if (num_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wait_hi(input int w);
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hs[w] !== 1'b1 && n < 200);
		if (hs[w] !== 1'b1) begin
			num_errors++;
			report_and_stop;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back({r, 32'h0});
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		fork
			begin
				wait_hi(0);
				awv <= 1'b0;
			end
			begin
				wait_hi(1);
				wv <= 1'b0;
			end
		join
		bry <= 1'b1;
		wait_hi(2);
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		arv <= 1'b1;
		ara <= a;
		wait_hi(3);
		arv <= 1'b0;
		rry <= 1'b1;
		wait_hi(4);
		rry <= 1'b0;
	endtask
	task automatic pins(input logic [1:0] e);
		repeat (3) @(posedge clk);
		check("pin_out", {32'h0, pin}, {32'h0, e});
		check("pin_oe", {32'h0, oe}, {32'h0, pdir});
	endtask
	task automatic run(input logic [31:0] ctrl, input int n);
		wr(8'h00, ctrl | 32'h100, 2'h0);
		repeat (n) @(posedge clk);
		wr(8'h00, ctrl, 2'h0);
	endtask
	always @(posedge clk) begin
		if (bv && bry) check("bresp", {br, 32'h0}, bq.pop_front());
		if (rv && rry) check("rdata", {rr, rdat}, rq.pop_front());
	end
	initial begin
		{srst, awv, wv, bry, arv, rry, awa, ara, wd, ack, pdat, pdir} = {1'b1, 60'h0};
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h1c, 32'h0, 2'h2);
		wr(8'h1c, 32'h1, 2'h2);
		wr(8'h00, 32'hfffff8ff, 2'h0);
		rd(8'h00, 32'hf7, 2'h0);
		pdat <= 2'($random(seed));
		wr(8'h00, 32'h30, 2'h0);
		wr(8'h14, 32'h3, 2'h0);
		pdir <= 2'h3;
		pins({pdat[1], 1'b1});
		rd(8'h10, 32'h0, 2'h0);
		wr(8'h00, 32'h10, 2'h0);
		wr(8'h14, 32'h1, 2'h0);
		pins({pdat[1], 1'b0});
		wr(8'h00, 32'h0, 2'h0);
		pins(pdat);
		wr(8'h00, 32'hd2, 2'h0);
		pins(2'h0);
		wr(8'h00, 32'h0, 2'h0);
		wr(8'h08, 32'h30, 2'h0);
		wr(8'h0c, 32'h80, 2'h0);
		wr(8'h04, 32'h30, 2'h0);
		rd(8'h04, 32'h30, 2'h0);
		run(32'h0, 20);
		rd(8'h10, 32'h0, 2'h0);
		wr(8'h18, 32'h7, 2'h0);
		wr(8'h08, 32'h5, 2'h0);
		wr(8'h04, 32'hfe, 2'h0);
		run(32'h0, 10);
		rd(8'h10, 32'h5, 2'h0);
		check("irq", {31'h0, irq}, 34'h5);
		wr(8'h10, 32'h1, 2'h0);
		rd(8'h10, 32'h4, 2'h0);
		ack <= 3'h4;
		@(posedge clk);
		ack <= 3'h0;
		rd(8'h10, 32'h0, 2'h0);
		wr(8'h08, 32'h10, 2'h0);
		wr(8'h04, 32'h20, 2'h0);
		run(32'h2, 20);
		rd(8'h10, 32'h0, 2'h0);
		wr(8'h04, 32'hfc, 2'h0);
		run(32'h2, 40);
		rd(8'h10, 32'h5, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		wr(8'h08, 32'h40, 2'h0);
		rd(8'h08, 32'h40, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
		rd(8'h08, 32'h10, 2'h0);
		wr(8'h04, 32'hfe, 2'h0);
		run(32'h1, 5);
		wr(8'h00, 32'h0, 2'h0);
		rd(8'h08, 32'h40, 2'h0);
		wr(8'h08, 32'h3, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		run(32'h12, 2);
		pins({pdat[1], 1'b1});
		rd(8'h04, 32'h1, 2'h0);
		repeat (2) @(posedge clk);
		report_and_stop;
	end
endmodule
`default_nettype wire
